// ===== hw/sfp_cfg.svh
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

// storage geometry
`define SFP_IDX_W      8
`define SFP_TAG_W      20
`define SFP_DC_WORDS   4

// register byte offsets
`define SFP_OFS_CTRL   4'h0
`define SFP_OFS_STAT   4'h4
`define SFP_OFS_MASK   4'h8
`define SFP_OFS_ECNT   4'hc

// control fields and reset value
`define SFP_CTRL_ECC   0
`define SFP_CTRL_WB    1
`define SFP_CTRL_RST   2'h1

// status and mask fields
`define SFP_ST_W       8
`define SFP_ST_IC      0
`define SFP_ST_DC      1
`define SFP_ST_TLBX    2
`define SFP_ST_TLBR    3
`define SFP_ST_BTC     4
`define SFP_ST_IBUS    5
`define SFP_ST_DBUS    6
`define SFP_ST_FATAL   7
`define SFP_MASK_RST   8'h00

// parity error counter
`define SFP_CNT_W      16

`endif

// ===== hw/sfp_pkg.sv
`include "sfp_cfg.svh"

package sfp_pkg;

	// cache write or hit access; instruction cache uses word 0 only
	typedef struct packed {
		logic                            en;
		logic [`SFP_IDX_W-1:0]           idx;
		logic [`SFP_TAG_W-1:0]           tag;
		logic [`SFP_DC_WORDS*32-1:0]     dat;
		logic                            tag_p;
		logic [`SFP_DC_WORDS-1:0]        dat_p;
	} sfp_cache_type;

	typedef struct packed {
		logic                            en;
		logic [`SFP_IDX_W-1:0]           idx;
		logic                            tag_p;
		logic [`SFP_DC_WORDS-1:0]        dat_p;
	} sfp_cpar_type;

	typedef struct packed {
		logic                            en;
		logic [`SFP_IDX_W-1:0]           idx;
		logic                            par;
	} sfp_pst_type;

	typedef struct packed {
		logic                            en;
		logic [`SFP_IDX_W-1:0]           idx;
	} sfp_inv_type;

	typedef struct packed {
		logic                            en;
		logic [`SFP_IDX_W-1:0]           idx;
		logic [31:0]                     hi;
		logic [31:0]                     lo;
		logic                            par;
	} sfp_tlb_type;

	typedef struct packed {
		logic                            en;
		logic [`SFP_IDX_W-1:0]           idx;
		logic [31:0]                     addr;
		logic                            par;
	} sfp_btc_type;

	typedef struct packed {
		logic                            cyc;
		logic                            stb;
		logic                            we;
		logic [31:0]                     adr;
		logic [3:0]                      sel;
		logic [31:0]                     dat;
	} sfp_wbi_type;

	typedef enum logic [1:0] {
		SFP_RUN  = 2'b00,
		SFP_EXC  = 2'b01,
		SFP_HALT = 2'b10
	} sfp_state_type;

	// even parity: stored bit makes the total count of ones even
	function automatic logic sfp_par32(input logic [31:0] d);
		return ^d;
	endfunction : sfp_par32

	function automatic logic sfp_tag_par(input logic [`SFP_TAG_W-1:0] t);
		return ^t;
	endfunction : sfp_tag_par

endpackage : sfp_pkg

// ===== hw/sfp_cache_chk.sv
`timescale 1ns/1ps
`include "sfp_cfg.svh"

module sfp_cache_chk #(
	parameter int WORDS = 1
) (
	// hit access with stored parity
	input  sfp_pkg::sfp_cache_type acc_i,
	// mismatch, combinational
	output logic                   err_o
);
	import sfp_pkg::*;

	logic [`SFP_DC_WORDS-1:0] werr;

	always_comb begin
		werr = '0;
		for (int i = 0; i < WORDS; i++) begin
			werr[i] = sfp_par32(acc_i.dat[i*32 +: 32]) ^ acc_i.dat_p[i];
		end
	end

	assign err_o = acc_i.en & ((sfp_tag_par(acc_i.tag) ^ acc_i.tag_p) | (|werr));

endmodule : sfp_cache_chk

// ===== hw/sfp_top.sv
`timescale 1ns/1ps
`include "sfp_cfg.svh"
// What this block does
// [R1] with fault tolerance on, check all internal rams and accept memory ecc errors
// [R2] cache parity mismatch invalidates the line so it is fetched again
// [R3] cache parity is checked on every access that hits
// [R4] with fault tolerance on the data cache is write-through only
// [R5] cache writes store tag parity, instruction data parity, one bit per data word
// [R6] translation parity mismatch during lookup raises a tlb miss
// [R7] software translation entry writes store one parity bit per entry
// [R8] software translation entry reads check parity and clear valid on mismatch
// [R9] branch target parity mismatch drops the prediction, branch runs unpredicted
// [R10] branch target writes store one fresh parity bit per address
// [R11] the memory controller drives error flags when its ram has an error
// [R12] with exception_enable set, uncorrectable errors raise instruction or data bus exceptions
// [R13] bus exception during an exception halts the core and sets fatal_error_out
// [R14] internal parity stays active when memory ecc is switched off
// [R15] even parity over exactly the covered bits, same function for write and check
module sfp_top #(
	parameter bit fault_tolerance_param = 1'b1
) (
	// clock and reset
	input  logic                    ref_clk_i,
	input  logic                    reset_i,
	// register bus
	input  sfp_pkg::sfp_wbi_type    wb_i,
	output logic [31:0]             wb_dat_o,
	output logic                    wb_ack_o,
	output logic                    irq_o,
	// instruction cache
	input  sfp_pkg::sfp_cache_type  ic_wr_i,
	input  sfp_pkg::sfp_cache_type  ic_hit_i,
	output sfp_pkg::sfp_cpar_type   ic_par_o,
	output sfp_pkg::sfp_inv_type    ic_inv_o,
	// data cache
	input  sfp_pkg::sfp_cache_type  dc_wr_i,
	input  sfp_pkg::sfp_cache_type  dc_hit_i,
	output sfp_pkg::sfp_cpar_type   dc_par_o,
	output sfp_pkg::sfp_inv_type    dc_inv_o,
	output logic                    dc_wt_only_o,
	// unified translation buffer
	input  sfp_pkg::sfp_tlb_type    tlb_wr_i,
	input  sfp_pkg::sfp_tlb_type    tlb_xl_i,
	input  sfp_pkg::sfp_tlb_type    tlb_rd_i,
	output sfp_pkg::sfp_pst_type    tlb_par_o,
	output logic                    tlb_miss_o,
	output sfp_pkg::sfp_inv_type    tlb_clrv_o,
	// branch target cache
	input  sfp_pkg::sfp_btc_type    btc_wr_i,
	input  sfp_pkg::sfp_btc_type    btc_lk_i,
	output sfp_pkg::sfp_pst_type    btc_par_o,
	output logic                    btc_take_o,
	output logic                    btc_drop_o,
	// local memory bus errors and exception state
	input  logic                    ilmb_ue_i,
	input  logic                    dlmb_ue_i,
	input  logic                    exception_enable_i,
	input  logic                    exc_active_i,
	input  logic                    exc_done_i,
	output logic                    ibus_exc_o,
	output logic                    dbus_exc_o,
	output logic                    fatal_error_out_o
);
	import sfp_pkg::*;

	localparam logic FT = fault_tolerance_param;

	function automatic logic tlb_par(input sfp_tlb_type e);
		return sfp_par32(e.hi) ^ sfp_par32(e.lo); // [R15]
	endfunction : tlb_par

	// bus registers
	logic                    wb_ack_r;
	logic [31:0]             wb_dat_r;
	logic [31:0]             rd_mux;
	logic [1:0]              ctrl_r;
	logic [1:0]              ctrl_nxt;
	logic [`SFP_ST_W-1:0]    stat_r;
	logic [`SFP_ST_W-1:0]    stat_nxt;
	logic [`SFP_ST_W-1:0]    st_set;
	logic [`SFP_ST_W-1:0]    st_clr;
	logic [`SFP_ST_W-1:0]    mask_r;
	logic [`SFP_CNT_W-1:0]   ecnt_r;
	logic                    irq_r;

	// parity paths
	logic                    ic_perr;
	logic                    dc_perr;
	logic                    ic_err;
	logic                    dc_err;
	logic                    tlbx_err;
	logic                    tlbr_err;
	logic                    btc_err;
	logic                    any_perr;
	logic [`SFP_DC_WORDS-1:0] dc_wp;
	sfp_cpar_type            ic_par_r;
	sfp_cpar_type            dc_par_r;
	sfp_inv_type             ic_inv_r;
	sfp_inv_type             dc_inv_r;
	sfp_pst_type             tlb_par_r;
	sfp_inv_type             tlb_clrv_r;
	sfp_pst_type             btc_par_r;
	logic                    tlb_miss_r;
	logic                    btc_take_r;
	logic                    btc_drop_r;

	// bus exception tracking
	sfp_state_type           st_r;
	sfp_state_type           st_nxt;
	logic                    ue_ok;
	logic                    iue;
	logic                    due;
	logic                    ue_any;
	logic                    busy;
	logic                    nest;
	logic                    take;
	logic                    ibus_r;
	logic                    dbus_r;
	logic                    fatal_r;

	// ---- register bus decode ----
	logic req;
	logic sel_ok;
	logic wr_now;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;

	assign req     = wb_i.cyc & wb_i.stb;
	assign sel_ok  = wb_i.adr[31:4] == 28'h0;
	// the write lands on the edge where the master samples ack
	assign wr_now  = req & wb_i.we & wb_ack_r & sel_ok & wb_i.sel[0];
	assign wr_ctrl = wr_now & (wb_i.adr[3:0] == `SFP_OFS_CTRL);
	assign wr_stat = wr_now & (wb_i.adr[3:0] == `SFP_OFS_STAT);
	assign wr_mask = wr_now & (wb_i.adr[3:0] == `SFP_OFS_MASK);

	always_comb begin
		rd_mux = 32'h0;
		if (sel_ok) begin
			case (wb_i.adr[3:0])
				`SFP_OFS_CTRL: rd_mux = {30'h0, ctrl_r};
				`SFP_OFS_STAT: rd_mux = {24'h0, stat_r};
				`SFP_OFS_MASK: rd_mux = {24'h0, mask_r};
				`SFP_OFS_ECNT: rd_mux = {16'h0, ecnt_r};
				default:       rd_mux = 32'h0;
			endcase
		end
	end

	// write-back can never be selected while protection is built in
	assign ctrl_nxt = wr_ctrl ? {wb_i.dat[`SFP_CTRL_WB] & ~FT, wb_i.dat[`SFP_CTRL_ECC]} : ctrl_r; // [R4]

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			wb_ack_r <= 1'b0;
			wb_dat_r <= 32'h0;
		end else begin
			wb_ack_r <= req & ~wb_ack_r;
			wb_dat_r <= (req & ~wb_ack_r) ? rd_mux : 32'h0;
		end
	end

	// ---- parity checks on hits and lookups ----
	sfp_cache_chk #(.WORDS(1)) u_ic_chk (
		.acc_i (ic_hit_i),
		.err_o (ic_perr)
	);

	sfp_cache_chk #(.WORDS(`SFP_DC_WORDS)) u_dc_chk (
		.acc_i (dc_hit_i),
		.err_o (dc_perr)
	);

	// checks depend only on the build option, never on memory ecc control
	assign ic_err   = FT & ic_perr; // [R1] [R3] [R14]
	assign dc_err   = FT & dc_perr; // [R3] [R14]
	assign tlbx_err = FT & tlb_xl_i.en & (tlb_par(tlb_xl_i) ^ tlb_xl_i.par); // [R6]
	assign tlbr_err = FT & tlb_rd_i.en & (tlb_par(tlb_rd_i) ^ tlb_rd_i.par); // [R8]
	assign btc_err  = FT & btc_lk_i.en & (sfp_par32(btc_lk_i.addr) ^ btc_lk_i.par); // [R9]
	assign any_perr = ic_err | dc_err | tlbx_err | tlbr_err | btc_err;

	always_comb begin
		dc_wp = '0;
		for (int i = 0; i < `SFP_DC_WORDS; i++) begin
			dc_wp[i] = sfp_par32(dc_wr_i.dat[i*32 +: 32]); // [R5]
		end
	end

	// parity for the write port, registered one cycle after the write request
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ic_par_r  <= '0;
			dc_par_r  <= '0;
			tlb_par_r <= '0;
			btc_par_r <= '0;
		end else begin
			ic_par_r  <= '{ic_wr_i.en, ic_wr_i.idx, sfp_tag_par(ic_wr_i.tag),
				{{(`SFP_DC_WORDS-1){1'b0}}, sfp_par32(ic_wr_i.dat[31:0])}}; // [R5]
			dc_par_r  <= '{dc_wr_i.en, dc_wr_i.idx, sfp_tag_par(dc_wr_i.tag), dc_wp}; // [R5]
			tlb_par_r <= '{tlb_wr_i.en, tlb_wr_i.idx, tlb_par(tlb_wr_i)}; // [R7]
			btc_par_r <= '{btc_wr_i.en, btc_wr_i.idx, sfp_par32(btc_wr_i.addr)}; // [R10]
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ic_inv_r   <= '0;
			dc_inv_r   <= '0;
			tlb_clrv_r <= '0;
			tlb_miss_r <= 1'b0;
			btc_take_r <= 1'b0;
			btc_drop_r <= 1'b0;
		end else begin
			ic_inv_r   <= '{ic_err, ic_hit_i.idx}; // [R2]
			dc_inv_r   <= '{dc_err, dc_hit_i.idx}; // [R2]
			tlb_clrv_r <= '{tlbr_err, tlb_rd_i.idx}; // [R8]
			tlb_miss_r <= tlbx_err; // [R6]
			btc_take_r <= btc_lk_i.en & ~btc_err; // [R9]
			btc_drop_r <= btc_err; // [R9]
		end
	end

	// ---- memory ecc errors to bus exceptions ----
	assign ue_ok  = FT & ctrl_r[`SFP_CTRL_ECC]; // [R1]
	assign iue    = ue_ok & ilmb_ue_i; // [R11]
	assign due    = ue_ok & dlmb_ue_i;
	assign ue_any = iue | due;
	assign busy   = (st_r == SFP_EXC) | exc_active_i;
	assign nest   = ue_any & busy & (st_r != SFP_HALT); // [R13]
	assign take   = ue_any & ~busy & exception_enable_i & (st_r == SFP_RUN); // [R12]

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			SFP_RUN: begin
				if (nest) st_nxt = SFP_HALT;
				else if (take) st_nxt = SFP_EXC;
			end
			SFP_EXC: begin
				if (nest) st_nxt = SFP_HALT;
				else if (exc_done_i) st_nxt = SFP_RUN;
			end
			SFP_HALT: st_nxt = SFP_HALT;
			default:  st_nxt = SFP_RUN;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			st_r    <= SFP_RUN;
			ibus_r  <= 1'b0;
			dbus_r  <= 1'b0;
			fatal_r <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			// instruction side wins when both report together
			ibus_r  <= take & iue; // [R12]
			dbus_r  <= take & ~iue; // [R12]
			fatal_r <= st_nxt == SFP_HALT; // [R13]
		end
	end

	// ---- status, mask, counter, interrupt ----
	assign st_set = {nest, take & ~iue, take & iue, btc_err, tlbr_err, tlbx_err, dc_err, ic_err};
	assign st_clr = wr_stat ? wb_i.dat[`SFP_ST_W-1:0] : '0;
	// a new event beats a clear in the same cycle
	assign stat_nxt = (stat_r & ~st_clr) | st_set;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ctrl_r <= `SFP_CTRL_RST;
			stat_r <= '0;
			mask_r <= `SFP_MASK_RST;
			irq_r  <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			stat_r <= stat_nxt;
			mask_r <= wr_mask ? wb_i.dat[`SFP_ST_W-1:0] : mask_r;
			irq_r  <= |(stat_r & mask_r);
		end
	end

	// counter saturates so a storm of errors cannot wrap to a small value
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) ecnt_r <= '0;
		else if (any_perr & ~&ecnt_r) ecnt_r <= ecnt_r + `SFP_CNT_W'(1);
	end

	assign wb_ack_o          = wb_ack_r;
	assign wb_dat_o          = wb_dat_r;
	assign irq_o             = irq_r;
	assign ic_par_o          = ic_par_r;
	assign ic_inv_o          = ic_inv_r;
	assign dc_par_o          = dc_par_r;
	assign dc_inv_o          = dc_inv_r;
	assign tlb_par_o         = tlb_par_r;
	assign tlb_miss_o        = tlb_miss_r;
	assign tlb_clrv_o        = tlb_clrv_r;
	assign btc_par_o         = btc_par_r;
	assign btc_take_o        = btc_take_r;
	assign btc_drop_o        = btc_drop_r;
	assign ibus_exc_o        = ibus_r;
	assign dbus_exc_o        = dbus_r;
	assign fatal_error_out_o = fatal_r;

	// dc_wt_only_o is a constant flop so it is defined from reset on
	logic wt_r;
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) wt_r <= 1'b0;
		else wt_r <= FT; // [R4]
	end
	assign dc_wt_only_o = wt_r;

	// ---- checks ----
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_ic_bad;
		FT && ic_hit_i.en && (sfp_tag_par(ic_hit_i.tag) ^ ic_hit_i.tag_p ^ sfp_par32(ic_hit_i.dat[31:0])
			^ ic_hit_i.dat_p[0] || sfp_tag_par(ic_hit_i.tag) != ic_hit_i.tag_p);
	endsequence
	sequence s_nest;
		(ilmb_ue_i || dlmb_ue_i) && ue_ok && (st_r == SFP_EXC || exc_active_i) && !fatal_error_out_o;
	endsequence
	sequence s_ibus_take;
		ilmb_ue_i && ue_ok && exception_enable_i && !exc_active_i && st_r == SFP_RUN;
	endsequence

	property p_ic_inv;
		s_ic_bad |=> ic_inv_o.en && ic_inv_o.idx == $past(ic_hit_i.idx);
	endproperty
	a_ic_inv: assert property (p_ic_inv) else $error("bad icache hit did not invalidate line"); // [R2]

	property p_inv_needs_hit;
		ic_inv_o.en || dc_inv_o.en |-> $past(ic_hit_i.en) || $past(dc_hit_i.en);
	endproperty
	a_inv_needs_hit: assert property (p_inv_needs_hit) else $error("invalidate without a hit"); // [R3]

	property p_wt;
		!$past(reset_i) |-> dc_wt_only_o == FT && !(FT && ctrl_r[`SFP_CTRL_WB]);
	endproperty
	a_wt: assert property (p_wt) else $error("write-back reachable with protection on"); // [R4]

	property p_dc_par;
		dc_wr_i.en |=> dc_par_o.en && dc_par_o.dat_p[1] == ^$past(dc_wr_i.dat[63:32])
			&& dc_par_o.tag_p == ^$past(dc_wr_i.tag);
	endproperty
	a_dc_par: assert property (p_dc_par) else $error("dcache write parity wrong"); // [R5]

	property p_tlb_miss;
		FT && tlb_xl_i.en && (^tlb_xl_i.hi ^ ^tlb_xl_i.lo) != tlb_xl_i.par |=> tlb_miss_o;
	endproperty
	a_tlb_miss: assert property (p_tlb_miss) else $error("tlb parity miss not raised"); // [R6]

	property p_tlb_par;
		tlb_wr_i.en |=> tlb_par_o.en && tlb_par_o.par == (^$past(tlb_wr_i.hi) ^ ^$past(tlb_wr_i.lo));
	endproperty
	a_tlb_par: assert property (p_tlb_par) else $error("tlb entry parity wrong"); // [R7]

	property p_tlb_clrv;
		tlb_clrv_o.en |-> $past(tlb_rd_i.en) && tlb_clrv_o.idx == $past(tlb_rd_i.idx);
	endproperty
	a_tlb_clrv: assert property (p_tlb_clrv) else $error("valid cleared without a read"); // [R8]

	property p_btc;
		btc_lk_i.en |=> btc_take_o != btc_drop_o
			&& btc_drop_o == (FT && (^$past(btc_lk_i.addr) != $past(btc_lk_i.par)));
	endproperty
	a_btc: assert property (p_btc) else $error("branch target kept despite parity error"); // [R9]

	property p_ibus;
		s_ibus_take |=> ibus_exc_o && !dbus_exc_o ##1 !ibus_exc_o;
	endproperty
	a_ibus: assert property (p_ibus) else $error("instruction bus exception not one pulse"); // [R12]

	property p_fatal;
		s_nest |=> fatal_error_out_o [*3];
	endproperty
	a_fatal: assert property (p_fatal) else $error("nested bus exception did not halt"); // [R13]

endmodule : sfp_top

// ===== dv/sfp_lmb_model.sv
`timescale 1ns/1ps
module sfp_lmb_model (
	// clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       reset_i,
	// error injection, bit0 instruction side, bit1 data side
	input  wire logic [1:0] inj_i,
	input  wire logic [2:0] lat_i,
	// uncorrectable error flags
	output logic            ilmb_ue_o,
	output logic            dlmb_ue_o
);
	logic [1:0] pend_r;
	logic [2:0] cnt_r;

	// the flag marks only the one access that read the bad word, so it lasts a single cycle
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || inj_i != 2'h0) begin
			pend_r    <= reset_i ? 2'h0 : inj_i;
			cnt_r     <= lat_i;
			ilmb_ue_o <= 1'b0;
			dlmb_ue_o <= 1'b0;
		end else begin
			pend_r    <= (cnt_r == 3'h0) ? 2'h0 : pend_r;
			cnt_r     <= (cnt_r == 3'h0) ? 3'h0 : cnt_r - 3'h1;
			ilmb_ue_o <= pend_r[0] && cnt_r == 3'h0;
			dlmb_ue_o <= pend_r[1] && cnt_r == 3'h0;
		end
	end
endmodule : sfp_lmb_model

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`include "sfp_cfg.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module tb_top;
	import sfp_pkg::*;
	logic          ref_clk_i, reset_i, wb_ack_o, irq_o, dc_wt_only_o;
	sfp_wbi_type   wb_i;
	logic [31:0]   wb_dat_o;
	sfp_cache_type ic_wr_i, ic_hit_i, dc_wr_i, dc_hit_i;
	sfp_cpar_type  ic_par_o, dc_par_o, ie[40], de[40];
	sfp_inv_type   ic_inv_o, dc_inv_o, tlb_clrv_o;
	sfp_tlb_type   tlb_wr_i, tlb_xl_i, tlb_rd_i, t;
	sfp_pst_type   tlb_par_o, btc_par_o, te[40], be[40];
	sfp_btc_type   btc_wr_i, btc_lk_i, b;
	sfp_cache_type c;
	logic          ilmb_ue_i, dlmb_ue_i, exception_enable_i, exc_active_i, exc_done_i;
	logic          ibus_exc_o, dbus_exc_o, fatal_error_out_o, tlb_miss_o, btc_take_o, btc_drop_o;
	logic [1:0]    inj;
	logic [2:0]    lat, s;
	logic [7:0]    st_e;
	int            err_count, n_checks, perr, i;

	sfp_top uut (.ref_clk_i, .reset_i, .wb_i, .wb_dat_o, .wb_ack_o, .irq_o, .ic_wr_i, .ic_hit_i, .ic_par_o,
		.ic_inv_o, .dc_wr_i, .dc_hit_i, .dc_par_o, .dc_inv_o, .dc_wt_only_o, .tlb_wr_i, .tlb_xl_i, .tlb_rd_i,
		.tlb_par_o, .tlb_miss_o, .tlb_clrv_o, .btc_wr_i, .btc_lk_i, .btc_par_o, .btc_take_o, .btc_drop_o,
		.ilmb_ue_i, .dlmb_ue_i, .exception_enable_i, .exc_active_i, .exc_done_i, .ibus_exc_o, .dbus_exc_o,
		.fatal_error_out_o);
	sfp_lmb_model lmb (.ref_clk_i, .reset_i, .inj_i(inj), .lat_i(lat), .ilmb_ue_o(ilmb_ue_i),
		.dlmb_ue_o(dlmb_ue_i));

	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	function automatic logic xr(input logic [127:0] d, input int n);
		logic p;
		p = 1'b0;
		for (int k = 0; k < n; k++) p ^= d[k];
		return p;
	endfunction : xr

	function automatic logic [3:0] dp(input logic [127:0] d);
		for (int k = 0; k < 4; k++) dp[k] = xr(128'(d[32*k+:32]), 32);
	endfunction : dp

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict

	// waits for ack under a bound; the slave answers one cycle after it sees the request
	task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		wb_i <= '{1'b1, 1'b1, we, a, 4'hf, d};
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 8);
		if (wb_ack_o !== 1'b1) begin
			err_count++;
			$display("MISMATCH wb_ack exp 1 got %b", wb_ack_o);
			print_verdict();
		end else begin
			q = wb_dat_o;
			wb_i <= '0;
			@(posedge ref_clk_i);
		end
	endtask : wb

	task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, 32'(a), 32'h0, q);
		`CHK(nm, e, q)
	endtask : rd

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr

	task automatic rnd(output sfp_cache_type rc, output sfp_tlb_type rt, output sfp_btc_type rb);
		rc = '{1'b1, 8'($urandom()), 20'($urandom()), {$urandom(), $urandom(), $urandom(), $urandom()},
			1'($urandom()), 4'($urandom())};
		rt = '{1'b1, 8'($urandom()), $urandom(), $urandom(), 1'($urandom())};
		rb = '{1'b1, 8'($urandom()), $urandom(), 1'($urandom())};
	endtask : rnd

	// m: bit0 icache, bit1 dcache, bit2 translate, bit3 entry read, bit4 branch target
	task automatic probe(input logic [4:0] m);
		sfp_cache_type pc, ic;
		sfp_tlb_type   pt, tx;
		sfp_btc_type   pb;
		int            w;
		logic [5:0]    fl;
		rnd(pc, pt, pb);
		pc.dat_p = dp(pc.dat);
		pc.tag_p = xr(128'(pc.tag), `SFP_TAG_W);
		ic = pc;
		ic.dat_p[3:1] = 3'h0;
		w = $urandom_range(0, 4);
		ic.tag_p ^= m[0] & w[0];
		ic.dat_p[0] ^= m[0] & ~w[0];
		pc.tag_p ^= m[1] && w == 4;
		if (m[1] && w < 4) pc.dat_p[w] ^= 1'b1;
		pt.par = xr({64'h0, pt.hi, pt.lo}, 64) ^ m[3];
		tx = pt;
		tx.par = pt.par ^ m[3] ^ m[2];
		pb.par = xr(128'(pb.addr), 32) ^ m[4];
		ic_hit_i <= ic;
		dc_hit_i <= pc;
		tlb_xl_i <= tx;
		tlb_rd_i <= pt;
		btc_lk_i <= pb;
		@(posedge ref_clk_i);
		{ic_hit_i, dc_hit_i, tlb_xl_i, tlb_rd_i, btc_lk_i} <= '0;
		@(posedge ref_clk_i);
		fl = {btc_drop_o, tlb_clrv_o.en, tlb_miss_o, dc_inv_o.en, ic_inv_o.en, btc_take_o};
		`CHK("flags", {m, ~m[4]}, fl)
		`CHK("ic_idx", m[0] ? pc.idx : ic_inv_o.idx, ic_inv_o.idx)
		`CHK("dc_idx", m[1] ? pc.idx : dc_inv_o.idx, dc_inv_o.idx)
		`CHK("tlb_idx", m[3] ? pt.idx : tlb_clrv_o.idx, tlb_clrv_o.idx)
		st_e |= {3'h0, m};
		perr += int'(m != 5'h0);
	endtask : probe

	task automatic watch(output logic [2:0] o);
		o = 3'h0;
		repeat (16) begin
			@(posedge ref_clk_i);
			o |= {fatal_error_out_o, dbus_exc_o, ibus_exc_o};
		end
	endtask : watch

	task automatic inject(input logic [1:0] w);
		inj <= w;
		lat <= 3'($urandom());
		@(posedge ref_clk_i);
		inj <= 2'h0;
	endtask : inject

	task automatic done_pulse();
		exc_done_i <= 1'b1;
		@(posedge ref_clk_i);
		exc_done_i <= 1'b0;
	endtask : done_pulse

	task automatic do_reset();
		reset_i <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		// outputs take their running values on the first edge after release
		repeat (2) @(posedge ref_clk_i);
	endtask : do_reset

	initial begin
		void'($urandom(48919));
		{wb_i, ic_wr_i, ic_hit_i, dc_wr_i, dc_hit_i, tlb_wr_i, tlb_xl_i, tlb_rd_i, btc_wr_i, btc_lk_i} = '0;
		{exception_enable_i, exc_active_i, exc_done_i, inj, lat} = '0;
		{err_count, n_checks, perr, st_e} = '0;
		reset_i = 1'b1;
		do_reset();
		`CHK("wt_only", 1'b1, dc_wt_only_o)
		rd("ctrl", `SFP_OFS_CTRL, 32'h1);
		wr(32'(`SFP_OFS_CTRL), 32'h3);
		rd("ctrl_wb", `SFP_OFS_CTRL, 32'h1);
		rd("mask", `SFP_OFS_MASK, 32'h0);
		// an aliased write here would clear the ecc accept bit
		wr(32'h10, 32'h0);
		rd("unmapped", 4'h0, 32'h1);
		rd("hole", 4'h2, 32'h0);
		$display("test registers done");
		for (i = 0; i < 42; i++) begin
			@(posedge ref_clk_i);
			if (i >= 2) begin
				`CHK("ic_par", ie[i-2], ic_par_o)
				`CHK("dc_par", de[i-2], dc_par_o)
				`CHK("tlb_par", te[i-2], tlb_par_o)
				`CHK("btc_par", be[i-2], btc_par_o)
			end
			if (i < 40) begin
				rnd(c, t, b);
				c.dat = (i == 0) ? 128'h0 : (i == 1) ? '1 : c.dat;
				ic_wr_i <= c;
				dc_wr_i <= c;
				tlb_wr_i <= t;
				btc_wr_i <= b;
				ie[i] = '{1'b1, c.idx, xr(128'(c.tag), `SFP_TAG_W), {3'h0, xr(c.dat, 32)}};
				de[i] = '{1'b1, c.idx, xr(128'(c.tag), `SFP_TAG_W), dp(c.dat)};
				te[i] = '{1'b1, t.idx, xr({64'h0, t.hi, t.lo}, 64)};
				be[i] = '{1'b1, b.idx, xr(128'(b.addr), 32)};
			end else begin
				{ic_wr_i, dc_wr_i, tlb_wr_i, btc_wr_i} <= '0;
			end
		end
		$display("test parity write done");
		for (i = 0; i < 30; i++) probe(i == 0 ? 5'h0 : i < 6 ? 5'(1 << (i - 1)) : i == 6 ? 5'h1f : 5'($urandom()));
		`CHK("irq_masked", 1'b0, irq_o)
		rd("status", `SFP_OFS_STAT, 32'(st_e));
		rd("count", `SFP_OFS_ECNT, 32'(perr));
		wr(32'(`SFP_OFS_MASK), 32'h1);
		repeat (2) @(posedge ref_clk_i);
		`CHK("irq_on", 1'b1, irq_o)
		wr(32'(`SFP_OFS_STAT), 32'h1);
		repeat (2) @(posedge ref_clk_i);
		`CHK("irq_clr", 1'b0, irq_o)
		st_e[0] = 1'b0;
		$display("test parity check done");
		wr(32'(`SFP_OFS_CTRL), 32'h0);
		probe(5'h1f);
		exception_enable_i <= 1'b1;
		inject(2'h1);
		watch(s);
		`CHK("ecc_off", 3'h0, s)
		wr(32'(`SFP_OFS_CTRL), 32'h1);
		$display("test ecc off done");
		inject(2'h1);
		watch(s);
		`CHK("ibus", 3'h1, s)
		done_pulse();
		inject(2'h2);
		watch(s);
		`CHK("dbus", 3'h2, s)
		done_pulse();
		exception_enable_i <= 1'b0;
		inject(2'h1);
		watch(s);
		`CHK("ee_off", 3'h0, s)
		exception_enable_i <= 1'b1;
		exc_active_i <= 1'b1;
		inject(2'h2);
		watch(s);
		`CHK("nested", 3'h4, s)
		exc_active_i <= 1'b0;
		inject(2'h1);
		watch(s);
		`CHK("halted", 3'h4, s)
		rd("status_exc", `SFP_OFS_STAT, 32'(st_e | 8'he0));
		do_reset();
		`CHK("fatal_rst", 1'b0, fatal_error_out_o)
		inject(2'h1);
		watch(s);
		`CHK("ibus_rst", 3'h1, s)
		inject(2'h2);
		watch(s);
		`CHK("own_nest", 3'h4, s)
		$display("test exceptions done");
		print_verdict();
	end
endmodule : tb_top
